// [logic/exec_pkg.sv]
// shared constants, carrier types and opcode decode for the bit/call executor
// Notes on behaviour
// - bit_false_branch jumps on a 0 bit; 3 bytes, 10 cycles, opcode 37.
// - bit_true_branch jumps on a 1 bit, else goes on; opcode 37, 10 cycles.
// - byte 2: 4-bit register, 3-bit bit index, select 0 false 1 true.
// - neither bit-branch form changes any flag, taken or not.
// - bit_exclusive_or xors bit b with bit 0, writes one bit of the dst.
// - bit_exclusive_or: zero set on a 0 result, sign cleared, C, D, H kept.
// - bit_exclusive_or: 3 bytes, 6 cycles, opcode 27; sel 1 writes bit b.
// - a call decrements the stack pointer and pushes the pc before jumping.
// - the pushed pc is the address right after the call instruction.
// - call then loads pc from word F6 3/14, pair F4 2/12, vector D4 2/14.
// - procedure_exit pops the top of the stack back into the pc.
// - carry_flip inverts carry only; one byte, opcode EF, 4 cycles.
// - the carry it inverts lives in the flags register at address D5.
// - zero_fill clears its dst, keeps flags; 2 bytes, 4 cycles, B0 or B1.
// - indirect zero_fill clears what the pointer names, not the pointer.
package exec_pkg;
    // opcodes
    localparam logic [7:0] OPC_BIT_BRANCH = 8'h37;
    localparam logic [7:0] OPC_BIT_XOR = 8'h27;
    localparam logic [7:0] OPC_CALL_DIRECT = 8'hf6;
    localparam logic [7:0] OPC_CALL_PAIR = 8'hf4;
    localparam logic [7:0] OPC_CALL_VECTOR = 8'hd4;
    localparam logic [7:0] OPC_CARRY_FLIP = 8'hef;
    localparam logic [7:0] OPC_FILL_DIRECT = 8'hb0;
    localparam logic [7:0] OPC_FILL_INDIRECT = 8'hb1;
    localparam logic [7:0] OPC_EXIT = 8'hfe;
    // execution cycles
    localparam logic [4:0] CYC_BIT_BRANCH = 5'h0a;
    localparam logic [4:0] CYC_BIT_XOR = 5'h06;
    localparam logic [4:0] CYC_CALL_DIRECT = 5'h0e;
    localparam logic [4:0] CYC_CALL_PAIR = 5'h0c;
    localparam logic [4:0] CYC_CALL_VECTOR = 5'h0e;
    localparam logic [4:0] CYC_CARRY_FLIP = 5'h04;
    localparam logic [4:0] CYC_FILL = 5'h04;
    localparam logic [4:0] CYC_EXIT = 5'h08;
    // encoded lengths in bytes
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    // register file layout
    localparam logic [7:0] FLAGS_ADDR = 8'hd5;
    localparam logic [3:0] WORK_BASE = 4'h0;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    // apb map, byte addresses
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_SP = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_WIN_ADDR = 8'h14;
    localparam logic [7:0] OFS_WIN_DATA = 8'h18;
    localparam int ST_BUSY = 0;
    localparam int ST_ILLEGAL = 1;
    localparam int ST_TAKEN = 2;
    // reset values
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] SP_RST = 8'h00;

    typedef struct packed {
        logic legal;
        logic [1:0] len;
        logic [4:0] cyc;
    } op_info_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // length and cycle count of one opcode
    function automatic op_info_t decode_op(input logic [7:0] opc);
        op_info_t r;
        r = '{legal: 1'b1, len: LEN_1, cyc: CYC_EXIT};
        case (opc)
            OPC_BIT_BRANCH: r = '{1'b1, LEN_3, CYC_BIT_BRANCH};
            OPC_BIT_XOR: r = '{1'b1, LEN_3, CYC_BIT_XOR};
            OPC_CALL_DIRECT: r = '{1'b1, LEN_3, CYC_CALL_DIRECT};
            OPC_CALL_PAIR: r = '{1'b1, LEN_2, CYC_CALL_PAIR};
            OPC_CALL_VECTOR: r = '{1'b1, LEN_2, CYC_CALL_VECTOR};
            OPC_CARRY_FLIP: r = '{1'b1, LEN_1, CYC_CARRY_FLIP};
            OPC_FILL_DIRECT: r = '{1'b1, LEN_2, CYC_FILL};
            OPC_FILL_INDIRECT: r = '{1'b1, LEN_2, CYC_FILL};
            OPC_EXIT: r = '{1'b1, LEN_1, CYC_EXIT};
            default: r.legal = 1'b0;
        endcase
        return r;
    endfunction
endpackage

// [logic/reg_bank.sv]
// register file with combinational reads and two ordered write ports
`timescale 1ns/1ps
`default_nettype none
module reg_bank #(
    parameter int NRD = 4
) (
    input wire logic ref_clk, // core clock
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable
    input wire logic [NRD-1:0][7:0] rd_addr, // read addresses
    output logic [NRD-1:0][7:0] rd_data, // read data
    input wire exec_pkg::reg_write_t wr0, // first write port
    input wire exec_pkg::reg_write_t wr1 // second port, wins a clash
);
    logic [7:0] mem_q [256];

    if (NRD < 1) begin : g_bad_nrd
        $error("NRD must be at least 1");
    end

    // reads are plain array lookups
    genvar g;
    generate
        for (g = 0; g < NRD; g++) begin : g_rd
            assign rd_data[g] = mem_q[rd_addr[g]];
        end
    endgenerate

    // cleared at reset so flags start defined; wr1 comes last on purpose
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 256; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (ce) begin
            if (wr0.en) begin
                mem_q[wr0.addr] <= wr0.data;
            end
            if (wr1.en) begin
                mem_q[wr1.addr] <= wr1.data;
            end
        end
    end
endmodule
`default_nettype wire

// [logic/bit_unit.sv]
// bit test and single-bit exclusive-or datapath
`timescale 1ns/1ps
`default_nettype none
module bit_unit (
    input wire logic sel, // selector bit of the operand byte
    input wire logic [2:0] bidx, // bit index b
    input wire logic [7:0] near_val, // working register operand
    input wire logic [7:0] far_val, // full-address register operand
    input wire logic [7:0] flags_in, // current flags
    output logic taken, // branch condition met
    output logic xbit, // xor result bit
    output logic [7:0] xbyte, // destination value after xor
    output logic [7:0] flags_x // flags after xor
);
    // branch on false when sel is 0, on true when 1
    assign taken = (near_val[bidx] == sel);

    // sel 0 writes bit 0 of the working reg, sel 1 writes bit b of the far reg
    always_comb begin
        xbyte = near_val;
        if (sel) begin
            xbit = far_val[bidx] ^ near_val[0];
            xbyte = far_val;
            xbyte[bidx] = xbit;
        end else begin
            xbit = near_val[0] ^ far_val[bidx];
            xbyte[0] = xbit;
        end
    end

    // zero follows the result, sign clears, the rest is kept
    always_comb begin
        flags_x = flags_in;
        flags_x[exec_pkg::FLAG_Z] = ~xbit;
        flags_x[exec_pkg::FLAG_S] = 1'b0;
    end
endmodule
`default_nettype wire

// [logic/bit_call_exec.sv]
// executor for bit branches, bit xor, call/return, carry flip and clear
`timescale 1ns/1ps
`default_nettype none
module bit_call_exec #(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk, // core clock, 100 MHz
    input wire logic srst, // synchronous reset, high
    input wire logic ce, // clock enable, freezes all state
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data, registered
    output logic pslverr, // unmapped offset
    output logic [15:0] pm_addr, // program memory vector address
    input wire logic [15:0] pm_rdata, // vector word, high byte first
    output logic busy // instruction in flight
);
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be between 5 and 32");
    end

    typedef struct packed {
        logic busy;
        logic [4:0] cnt;
        logic [23:0] instr;
        logic [15:0] pc;
        logic [7:0] sp;
        logic illegal;
        logic taken;
        logic [7:0] win;
        logic [31:0] prdata;
        logic rdv;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic [3:0][7:0] rd_addr;
    logic [3:0][7:0] rd_data;
    exec_pkg::reg_write_t wr0;
    exec_pkg::reg_write_t wr1;
    exec_pkg::op_info_t info;
    exec_pkg::op_info_t new_info;
    logic [7:0] opc;
    logic [7:0] op_b2;
    logic [7:0] op_b3;
    logic [7:0] work_addr;
    logic [7:0] flags;
    logic [15:0] next_pc;
    logic [15:0] br_target;
    logic commit;
    logic acc;
    logic br_taken;
    logic xbit;
    logic [7:0] xbyte;
    logic [7:0] flags_x;
    logic [7:0] ofs;
    logic hit;

    // offset decode, used for the error answer and to gate writes
    function automatic logic mapped(input logic [7:0] a);
        return a == exec_pkg::OFS_INSTR || a == exec_pkg::OFS_PC ||
            a == exec_pkg::OFS_SP || a == exec_pkg::OFS_FLAGS ||
            a == exec_pkg::OFS_STATUS || a == exec_pkg::OFS_WIN_ADDR ||
            a == exec_pkg::OFS_WIN_DATA;
    endfunction

    assign opc = st_q.instr[23:16];
    assign op_b2 = st_q.instr[15:8];
    assign op_b3 = st_q.instr[7:0];
    assign work_addr = {exec_pkg::WORK_BASE, op_b2[7:4]};
    assign info = exec_pkg::decode_op(opc);
    assign new_info = exec_pkg::decode_op(pwdata[23:16]);
    assign flags = rd_data[2];
    // return address is the byte after this instruction
    assign next_pc = st_q.pc + {14'h0000, info.len};
    // displacement is signed, relative to the following instruction
    assign br_target = next_pc + {{8{op_b3[7]}}, op_b3};
    assign commit = st_q.busy && st_q.cnt == 5'h00 && ce;
    assign ofs = 8'(paddr);
    assign hit = mapped(ofs) && paddr[ADDR_W-1:0] == ADDR_W'(ofs);
    // reads are captured only while idle, so the answer waits out a run
    assign pready = psel && penable && st_q.rdv && ce;
    assign acc = pready;
    assign pslverr = pready && !hit;
    assign prdata = st_q.prdata;
    assign busy = st_q.busy;
    assign pm_addr = {8'h00, op_b2};

    // operand read addresses per opcode
    always_comb begin
        rd_addr[0] = op_b2;
        rd_addr[1] = op_b3;
        rd_addr[2] = exec_pkg::FLAGS_ADDR;
        rd_addr[3] = st_q.win;
        case (opc)
            exec_pkg::OPC_BIT_BRANCH, exec_pkg::OPC_BIT_XOR: begin
                rd_addr[0] = work_addr;
            end
            exec_pkg::OPC_CALL_PAIR: begin
                rd_addr[1] = op_b2 + 8'h01;
            end
            exec_pkg::OPC_EXIT: begin
                rd_addr[0] = st_q.sp;
                rd_addr[1] = st_q.sp + 8'h01;
            end
            default: begin
            end
        endcase
    end

    reg_bank #(.NRD(4)) u_bank (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr0(wr0),
        .wr1(wr1)
    );

    bit_unit u_bit (
        .sel(op_b2[0]),
        .bidx(op_b2[3:1]),
        .near_val(rd_data[0]),
        .far_val(rd_data[1]),
        .flags_in(flags),
        .taken(br_taken),
        .xbit(xbit),
        .xbyte(xbyte),
        .flags_x(flags_x)
    );

    // next state: apb side while idle, execution while busy
    always_comb begin
        st_d = st_q;
        wr0 = '0;
        wr1 = '0;
        st_d.rdv = psel && !st_q.busy && !pready;
        if (psel && !st_q.busy) begin
            st_d.prdata = 32'h0000_0000;
            case (ofs)
                exec_pkg::OFS_INSTR: st_d.prdata[23:0] = st_q.instr;
                exec_pkg::OFS_PC: st_d.prdata[15:0] = st_q.pc;
                exec_pkg::OFS_SP: st_d.prdata[7:0] = st_q.sp;
                exec_pkg::OFS_FLAGS: st_d.prdata[7:0] = flags;
                exec_pkg::OFS_STATUS: begin
                    st_d.prdata[exec_pkg::ST_BUSY] = st_q.busy;
                    st_d.prdata[exec_pkg::ST_ILLEGAL] = st_q.illegal;
                    st_d.prdata[exec_pkg::ST_TAKEN] = st_q.taken;
                end
                exec_pkg::OFS_WIN_ADDR: st_d.prdata[7:0] = st_q.win;
                exec_pkg::OFS_WIN_DATA: st_d.prdata[7:0] = rd_data[3];
                default: st_d.prdata = 32'h0000_0000;
            endcase
        end
        if (acc && pwrite && hit) begin
            case (ofs)
                exec_pkg::OFS_INSTR: begin
                    if (new_info.legal) begin
                        st_d.instr = pwdata[23:0];
                        st_d.busy = 1'b1;
                        st_d.cnt = new_info.cyc - 5'h01;
                    end else begin
                        st_d.illegal = 1'b1;
                    end
                end
                exec_pkg::OFS_PC: st_d.pc = pwdata[15:0];
                exec_pkg::OFS_SP: st_d.sp = pwdata[7:0];
                exec_pkg::OFS_FLAGS: wr0 = '{1'b1, exec_pkg::FLAGS_ADDR,
                    pwdata[7:0]};
                exec_pkg::OFS_STATUS: begin
                    if (pwdata[exec_pkg::ST_ILLEGAL]) begin
                        st_d.illegal = 1'b0;
                    end
                end
                exec_pkg::OFS_WIN_ADDR: st_d.win = pwdata[7:0];
                exec_pkg::OFS_WIN_DATA: wr0 = '{1'b1, st_q.win, pwdata[7:0]};
                default: begin
                end
            endcase
        end
        if (st_q.busy && st_q.cnt != 5'h00) begin
            st_d.cnt = st_q.cnt - 5'h01;
        end
        if (st_q.busy && st_q.cnt == 5'h00) begin
            st_d.busy = 1'b0;
            st_d.pc = next_pc;
            case (opc)
                exec_pkg::OPC_BIT_BRANCH: begin
                    // no flag write on either outcome
                    st_d.taken = br_taken;
                    if (br_taken) begin
                        st_d.pc = br_target;
                    end
                end
                exec_pkg::OPC_BIT_XOR: begin
                    wr0 = '{1'b1, op_b2[0] ? op_b3 : work_addr, xbyte};
                    wr1 = '{1'b1, exec_pkg::FLAGS_ADDR, flags_x};
                end
                exec_pkg::OPC_CALL_DIRECT, exec_pkg::OPC_CALL_PAIR,
                exec_pkg::OPC_CALL_VECTOR: begin
                    // low byte lands on the higher address, high byte on top
                    wr0 = '{1'b1, st_q.sp - 8'h01, next_pc[7:0]};
                    wr1 = '{1'b1, st_q.sp - 8'h02, next_pc[15:8]};
                    st_d.sp = st_q.sp - 8'h02;
                    if (opc == exec_pkg::OPC_CALL_DIRECT) begin
                        st_d.pc = {op_b2, op_b3};
                    end else if (opc == exec_pkg::OPC_CALL_PAIR) begin
                        st_d.pc = {rd_data[0], rd_data[1]};
                    end else begin
                        st_d.pc = pm_rdata;
                    end
                end
                exec_pkg::OPC_EXIT: begin
                    st_d.pc = {rd_data[0], rd_data[1]};
                    st_d.sp = st_q.sp + 8'h02;
                end
                exec_pkg::OPC_CARRY_FLIP: begin
                    wr1 = '{1'b1, exec_pkg::FLAGS_ADDR,
                        flags ^ (8'h01 << exec_pkg::FLAG_C)};
                end
                exec_pkg::OPC_FILL_DIRECT: begin
                    wr0 = '{1'b1, op_b2, 8'h00};
                end
                exec_pkg::OPC_FILL_INDIRECT: begin
                    // the pointer is only read, its target is cleared
                    wr0 = '{1'b1, rd_data[0], 8'h00};
                end
                default: begin
                end
            endcase
        end
        if (!ce) begin
            wr0 = '0;
            wr1 = '0;
        end
    end

    // one register for all state; ce holds it still
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q <= '0;
            st_q.pc <= exec_pkg::PC_RST;
            st_q.sp <= exec_pkg::SP_RST;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    a_false_branch: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_BIT_BRANCH && !op_b2[0] &&
        !rd_data[0][op_b2[3:1]] |=> st_q.pc == $past(br_target))
        else $error("false branch did not jump on a zero bit");

    a_true_branch: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_BIT_BRANCH && op_b2[0] &&
        !rd_data[0][op_b2[3:1]] |=> st_q.pc == $past(next_pc))
        else $error("true branch did not fall through on a zero bit");

    a_branch_cycles: assert property (@(posedge ref_clk)
        disable iff (srst)
        acc && pwrite && ofs == exec_pkg::OFS_INSTR &&
        pwdata[23:16] == exec_pkg::OPC_BIT_BRANCH |=> st_q.busy &&
        st_q.cnt == 5'h09)
        else $error("bit branch did not load a ten cycle count");

    a_branch_flags: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_BIT_BRANCH |=> flags == $past(flags))
        else $error("bit branch altered the flags");

    a_xor_flags: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_BIT_XOR |=>
        flags[exec_pkg::FLAG_Z] == !$past(xbit) && !flags[exec_pkg::FLAG_S] &&
        flags[exec_pkg::FLAG_C] == $past(flags[exec_pkg::FLAG_C]))
        else $error("bit xor flags wrong");

    a_call_push: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && (opc == exec_pkg::OPC_CALL_DIRECT ||
        opc == exec_pkg::OPC_CALL_PAIR) |=> st_q.sp == $past(st_q.sp) - 8'h02)
        else $error("call did not move the stack pointer down by two");

    a_exit_pop: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_EXIT |=>
        st_q.sp == $past(st_q.sp) + 8'h02)
        else $error("exit did not move the stack pointer up by two");

    a_carry_flip: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_CARRY_FLIP |=>
        flags == ($past(flags) ^ 8'h80) &&
        st_q.pc == $past(st_q.pc) + 16'h0001)
        else $error("carry flip wrong");

    a_fill_flags: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_FILL_DIRECT &&
        op_b2 != exec_pkg::FLAGS_ADDR |=> flags == $past(flags) &&
        st_q.pc == $past(st_q.pc) + 16'h0002)
        else $error("zero fill changed flags or length");

    // the vector word is sampled only in the final cycle of the call
    a_vector_call: assert property (@(posedge ref_clk)
        disable iff (srst)
        commit && opc == exec_pkg::OPC_CALL_VECTOR |=>
        st_q.pc == $past(pm_rdata) && st_q.sp == $past(st_q.sp) - 8'h02)
        else $error("vector call did not load its target");
endmodule
`default_nettype wire

// [verification/bit_call_exec_tb.sv]
// self-checking bench for the bit, call, carry and clear executor
`timescale 1ns/1ps
`default_nettype none
module bit_call_exec_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] pm_rdata = 16'h0;
    logic pready;
    logic pslverr;
    logic busy;
    logic [31:0] prdata;
    logic [15:0] pm_addr;
    logic [31:0] q;
    logic e;
    int miscompares = 0;
    int checks = 0;

    // clock enable is driven so that a frozen run can be checked
    bit_call_exec dut (.ref_clk(ref_clk), .srst(srst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .busy(busy));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        checks++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    // one transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 60);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask

    task automatic set_reg(input logic [7:0] a, input logic [7:0] d);
        wr(exec_pkg::OFS_WIN_ADDR, {24'h0, a});
        wr(exec_pkg::OFS_WIN_DATA, {24'h0, d});
    endtask

    task automatic reg_chk(input string nm, input logic [7:0] a,
                           input logic [7:0] x);
        wr(exec_pkg::OFS_WIN_ADDR, {24'h0, a});
        rd_chk(nm, exec_pkg::OFS_WIN_DATA, {24'h0, x});
    endtask

    // start one instruction and count the cycles that busy stands
    task automatic run(input logic [23:0] ins, input logic [4:0] nc);
        int n;
        wr(exec_pkg::OFS_INSTR, {8'h00, ins});
        n = 0;
        do begin
            @(posedge ref_clk);
            if (busy === 1'b1) n++;
        end while (busy === 1'b1 && n < 40);
        chk("cycles", {27'h0, nc}, 32'(n));
    endtask

    // both polarities on a set and a clear bit, backward displacement
    task automatic t_branch();
        logic tk;
        set_reg(8'h03, 8'h08);
        for (int i = 0; i < 4; i++) begin
            tk = (i[1] == i[0]);
            wr(exec_pkg::OFS_PC, 32'h0100);
            wr(exec_pkg::OFS_FLAGS, 32'he4);
            run({exec_pkg::OPC_BIT_BRANCH, 4'h3, i[1] ? 3'd3 : 3'd2, i[0],
                 8'hf0}, exec_pkg::CYC_BIT_BRANCH);
            rd_chk("pc", exec_pkg::OFS_PC, tk ? 32'hf3 : 32'h103);
            rd_chk("flags", exec_pkg::OFS_FLAGS, 32'he4);
            rd_chk("status", exec_pkg::OFS_STATUS, {29'h0, tk, 2'h0});
        end
        $display("branch test done");
    endtask

    // both selector forms; flags start with every keepable bit set
    task automatic t_xor();
        set_reg(8'h02, 8'h07);
        set_reg(8'h40, 8'h03);
        wr(exec_pkg::OFS_FLAGS, 32'hbf);
        run({exec_pkg::OPC_BIT_XOR, 4'h2, 3'd1, 1'b0, 8'h40},
            exec_pkg::CYC_BIT_XOR);
        reg_chk("dst", 8'h02, 8'h06);
        reg_chk("src", 8'h40, 8'h03);
        rd_chk("flags", exec_pkg::OFS_FLAGS, 32'hdf);
        set_reg(8'h02, 8'h07);
        run({exec_pkg::OPC_BIT_XOR, 4'h2, 3'd2, 1'b1, 8'h40},
            exec_pkg::CYC_BIT_XOR);
        reg_chk("dst", 8'h40, 8'h07);
        reg_chk("src", 8'h02, 8'h07);
        rd_chk("flags", exec_pkg::OFS_FLAGS, 32'h9f);
        $display("xor test done");
    endtask

    // each call mode followed by an exit
    task automatic t_call();
        set_reg(8'h10, 8'h35);
        set_reg(8'h11, 8'h21);
        pm_rdata <= 16'h3521;
        for (int k = 0; k < 3; k++) begin
            wr(exec_pkg::OFS_PC, 32'h1a47);
            wr(exec_pkg::OFS_SP, 32'h80);
            if (k == 0) begin
                run({exec_pkg::OPC_CALL_DIRECT, 16'h3521},
                    exec_pkg::CYC_CALL_DIRECT);
            end else if (k == 1) begin
                run({exec_pkg::OPC_CALL_PAIR, 16'h1000},
                    exec_pkg::CYC_CALL_PAIR);
            end else begin
                run({exec_pkg::OPC_CALL_VECTOR, 16'h4000},
                    exec_pkg::CYC_CALL_VECTOR);
                chk("pm_addr", 32'h40, {16'h0, pm_addr});
            end
            rd_chk("pc", exec_pkg::OFS_PC, 32'h3521);
            rd_chk("sp", exec_pkg::OFS_SP, 32'h7e);
            reg_chk("ret_hi", 8'h7e, 8'h1a);
            reg_chk("ret_lo", 8'h7f, k == 0 ? 8'h4a : 8'h49);
            run({exec_pkg::OPC_EXIT, 16'h0}, exec_pkg::CYC_EXIT);
            rd_chk("pc", exec_pkg::OFS_PC,
                k == 0 ? 32'h1a4a : 32'h1a49);
            rd_chk("sp", exec_pkg::OFS_SP, 32'h80);
        end
        $display("call test done");
    endtask

    // flags reached through the register window at their own address
    task automatic t_carry();
        set_reg(exec_pkg::FLAGS_ADDR, 8'h7f);
        run({exec_pkg::OPC_CARRY_FLIP, 16'h0},
            exec_pkg::CYC_CARRY_FLIP);
        rd_chk("flags", exec_pkg::OFS_FLAGS, 32'hff);
        run({exec_pkg::OPC_CARRY_FLIP, 16'h0},
            exec_pkg::CYC_CARRY_FLIP);
        reg_chk("flags", exec_pkg::FLAGS_ADDR, 8'h7f);
        $display("carry test done");
    endtask

    task automatic t_fill();
        wr(exec_pkg::OFS_FLAGS, 32'h5a);
        set_reg(8'h30, 8'h4f);
        set_reg(8'h31, 8'h32);
        set_reg(8'h32, 8'h5e);
        run({exec_pkg::OPC_FILL_DIRECT, 16'h3000},
            exec_pkg::CYC_FILL);
        reg_chk("dst", 8'h30, 8'h00);
        run({exec_pkg::OPC_FILL_INDIRECT, 16'h3100},
            exec_pkg::CYC_FILL);
        reg_chk("target", 8'h32, 8'h00);
        reg_chk("pointer", 8'h31, 8'h32);
        rd_chk("flags", exec_pkg::OFS_FLAGS, 32'h5a);
        $display("fill test done");
    endtask

    // unmapped offset, then an opcode the executor refuses
    task automatic t_errors();
        apb(1'b0, 8'h1c, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        wr(exec_pkg::OFS_INSTR, 32'h00ff0000);
        chk("busy", 32'h0, {31'h0, busy});
        // bit 2 still holds the taken outcome of the last branch
        rd_chk("status", exec_pkg::OFS_STATUS, 32'h6);
        wr(exec_pkg::OFS_STATUS, 32'h2);
        rd_chk("status", exec_pkg::OFS_STATUS, 32'h4);
        $display("error test done");
    endtask

    // clock enable low for six edges must stretch a run, not cut it
    task automatic t_freeze();
        int n;
        wr(exec_pkg::OFS_INSTR, {8'h00, exec_pkg::OPC_CARRY_FLIP, 16'h0});
        ce <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("frozen busy", 32'h1, {31'h0, busy});
        ce <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            if (busy === 1'b1) n++;
        end while (busy === 1'b1 && n < 40);
        chk("cycles", {27'h0, exec_pkg::CYC_CARRY_FLIP}, 32'(n));
        rd_chk("flags", exec_pkg::OFS_FLAGS, 32'hda);
        $display("freeze test done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 5000 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rd_chk("sp", exec_pkg::OFS_SP, 32'h0);
        t_branch();
        t_xor();
        t_call();
        t_carry();
        t_fill();
        t_freeze();
        t_errors();
        tally_and_finish();
    end
endmodule
`default_nettype wire
